// ==== chan_pkg.sv ====
// Package of shared constants and types for the channel master and mode control.
// Assumes a single 10 MHz reference clock and no software-visible registers.
package chan_pkg;
  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int unsigned BUS_W        = 32;
  localparam int unsigned PAGE_W       = 10;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned STEP_CYCLES  = 1;
  localparam logic [31:0] WORD_STEP    = 32'h0000_0004;
  localparam logic [31:0] RESET_FETCH  = 32'h0000_0000;
  localparam logic [1:0]  PROT_SIMPLE  = 2'h0;
  localparam logic [1:0]  PROT_PIPE    = 2'h1;
  localparam logic [1:0]  PROT_BURST   = 2'h2;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_RESET, MODE_EXEC, MODE_WAIT, MODE_HOLD,
    MODE_HALT, MODE_STEP, MODE_LOADTEST, MODE_TEST
  } op_mode_t;

  typedef enum logic [1:0] {
    ACC_IDLE, ACC_ADDR, ACC_DATA
  } acc_state_t;
endpackage

// ==== addr_xlate.sv ====
// Address translation unit: maps a virtual page onto a physical page.
// Assumes the mapping base is supplied on the same clock by the caller.
`timescale 1ns/1ps
module addr_xlate
  import chan_pkg::*;
#(
  parameter int unsigned PW = PAGE_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_req,
  input  wire logic [31:0]      i_vaddr,
  input  wire logic [31-PW:0]   i_page_base,
  output logic                  o_valid,
  output logic [31:0]           o_paddr
);
  // ****************************************************************
  // Translation stage
  // ****************************************************************
  logic [31:0] paddr_d;
  assign paddr_d = {i_vaddr[31:PW] + i_page_base, i_vaddr[PW-1:0]};

  // Result registered in the execute stage, usable at write-back
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_valid <= 1'b0;
      o_paddr <= 32'h0000_0000;
    end else begin
      o_valid <= i_req;
      if (i_req) begin
        o_paddr <= paddr_d;
      end
    end
  end

  AST_XLATE_LATENCY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_req |=> o_valid && o_paddr[PW-1:0] == $past(i_vaddr[PW-1:0]))
    else $error("translation not ready one cycle after request");
endmodule // addr_xlate

// ==== chan_master.sv ====
// Channel master with operating-mode control for a pipelined processor core.
// Assumes core requests and debug controls on I_REF_CLK; pin inputs are synchronised here.
`timescale 1ns/1ps
module chan_master
  import chan_pkg::*;
#(
  parameter int unsigned W  = BUS_W,
  parameter int unsigned PW = PAGE_W
) (
  input  wire logic         I_REF_CLK,
  input  wire logic         I_RSTN,
  // Core side
  input  wire logic         i_supervisor,
  input  wire logic         i_wait_req,
  input  wire logic         i_irq_enabled,
  input  wire logic         i_halt_instr,
  input  wire logic         i_hazard,
  input  wire logic         i_branch,
  input  wire logic [W-1:0] i_branch_vaddr,
  input  wire logic         i_data_req,
  input  wire logic         i_data_wr,
  input  wire logic [W-1:0] i_data_vaddr,
  input  wire logic [W-1:0] i_data_wdata,
  input  wire logic [W-PW-1:0] i_page_base,
  input  wire logic         i_fetch_want,
  output logic              o_exec_en,
  output logic              o_instr_valid,
  output logic [W-1:0]      o_instr,
  output logic              o_data_done,
  output logic [W-1:0]      o_data_rdata,
  output logic              o_dbg_sel,
  // Channel pins
  output logic [W-1:0]      O_ADDR,
  output logic              O_ADDR_OE,
  output logic              O_IREQ,
  output logic              O_DREQ,
  output logic              O_DWR,
  output logic [1:0]        O_PROT,
  output logic              O_PRIV,
  output logic              O_BURST_REQ,
  input  wire logic [W-1:0] I_INSTR,
  input  wire logic         I_IRDY,
  input  wire logic         I_IBACK,
  input  wire logic [W-1:0] I_DATA,
  output logic [W-1:0]      O_DATA,
  output logic              O_DATA_OE,
  input  wire logic         I_DRDY,
  input  wire logic         I_PIPE_OK,
  input  wire logic         I_BGRANT_REQ,
  output logic              O_BGRANT,
  // Development pins
  input  wire logic         I_HALT,
  input  wire logic         I_STEP,
  input  wire logic         I_LOADTEST,
  input  wire logic         I_TEST,
  output logic [2:0]        O_MODE
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int unsigned NSYNC = 9;
  logic [NSYNC-1:0] pin_raw, sync1_q, sync2_q;
  assign pin_raw = {I_IRDY, I_IBACK, I_DRDY, I_PIPE_OK, I_BGRANT_REQ,
                    I_HALT, I_STEP, I_LOADTEST, I_TEST};
  // Two stages per pin; first stage read only by the second
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end
  logic irdy, iback, drdy, pipe_ok, breq, halt_pin, step_pin, lt_pin, test_pin;
  assign {irdy, iback, drdy, pipe_ok, breq, halt_pin, step_pin, lt_pin, test_pin} = sync2_q;
  // Buses sampled twice too; buses copied out every cycle, their ready marking the valid words
  logic [W-1:0] instr1_q, instr2_q, data1_q, data2_q;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      instr1_q <= '0;
      instr2_q <= '0;
      data1_q  <= '0;
      data2_q  <= '0;
    end else begin
      instr1_q <= I_INSTR;
      instr2_q <= instr1_q;
      data1_q  <= I_DATA;
      data2_q  <= data1_q;
    end
  end

  // ****************************************************************
  // Mode control
  // ****************************************************************
  op_mode_t mode_q, mode_d;
  logic     step_done_q, halt_seen_q;
  // Priority chain gives a single mode; reset is outside it and beats all
  always_comb begin
    mode_d = MODE_EXEC;
    if (test_pin) begin
      mode_d = MODE_TEST;
    end else if (lt_pin) begin
      mode_d = MODE_LOADTEST;
    end else if (step_pin) begin
      mode_d = step_done_q ? MODE_HALT : MODE_STEP;
    end else if (halt_pin || halt_seen_q) begin
      mode_d = MODE_HALT;
    end else if (mode_q == MODE_WAIT && !i_irq_enabled) begin
      mode_d = MODE_WAIT;
    end else if (i_wait_req && !i_irq_enabled) begin
      mode_d = MODE_WAIT;
    end else if (i_hazard) begin
      mode_d = MODE_HOLD;
    end
  end
  // Halt from an instruction latches until the pin requests step or load-test
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      mode_q      <= MODE_RESET;
      step_done_q <= 1'b0;
      halt_seen_q <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      step_done_q <= step_pin && (mode_d == MODE_STEP || step_done_q);
      halt_seen_q <= i_halt_instr || (halt_seen_q && !lt_pin && !step_pin);
    end
  end
  assign O_MODE    = mode_q;
  logic  running, fetching;
  assign running   = mode_q == MODE_EXEC || mode_q == MODE_STEP || mode_q == MODE_LOADTEST;
  assign fetching  = mode_q == MODE_EXEC || mode_q == MODE_STEP;
  assign o_exec_en = running;
  assign o_dbg_sel = mode_q == MODE_LOADTEST;

  // ****************************************************************
  // Arbitration: external master gets channel when no access is live
  // ****************************************************************
  acc_state_t dst_q, ist_q;
  logic       grant_q;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      grant_q <= 1'b0;
    end else begin
      // A parked fetch address does not block a master; a live burst or a data access does
      grant_q <= breq && (grant_q || (dst_q == ACC_IDLE && !(ist_q == ACC_DATA && fetching && i_fetch_want)));
    end
  end
  assign O_BGRANT = grant_q;

  // ****************************************************************
  // Translation and prefetch pointer
  // ****************************************************************
  logic         xl_req, xl_valid, pf_cross;
  logic [W-1:0] xl_vaddr, xl_paddr, pf_ptr_q, pf_phys_q;
  logic         pf_ok_q;
  assign pf_cross = pf_ptr_q[PW-1:0] == '0 && pf_ok_q;
  assign xl_req   = i_branch || i_data_req || (pf_cross && ist_q == ACC_IDLE);
  assign xl_vaddr = i_branch ? i_branch_vaddr : i_data_req ? i_data_vaddr : pf_ptr_q;

  addr_xlate #(.PW(PW)) i_addr_xlate (
    .i_clk       (I_REF_CLK),
    .i_rstn      (I_RSTN),
    .i_req       (xl_req),
    .i_vaddr     (xl_vaddr),
    .i_page_base (i_page_base),
    .o_valid     (xl_valid),
    .o_paddr     (xl_paddr)
  );
  logic xl_for_data_q;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      xl_for_data_q <= 1'b0;
    end else begin
      xl_for_data_q <= i_data_req && !i_branch;
    end
  end

  // ****************************************************************
  // Instruction stream: burst from translated start, pointer increments
  // ****************************************************************
  // Instruction traffic only while fetching is allowed and the channel is ours
  logic ifire, ilive;
  assign ilive = fetching && i_fetch_want && !grant_q;
  assign ifire = ist_q == ACC_DATA && irdy && ilive;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      ist_q     <= ACC_IDLE;
      pf_ptr_q  <= RESET_FETCH;
      pf_phys_q <= RESET_FETCH;
      pf_ok_q   <= 1'b0;
    end else begin
      if (i_branch) begin
        pf_ptr_q <= i_branch_vaddr;
        pf_ok_q  <= 1'b0;
        ist_q    <= ACC_IDLE;
      end else if (xl_valid && !xl_for_data_q) begin
        pf_phys_q <= xl_paddr;
        pf_ok_q   <= 1'b1;
        ist_q     <= ACC_ADDR;
      end else if (ist_q == ACC_ADDR && ilive && dst_q == ACC_IDLE) begin
        ist_q <= ACC_DATA;
      end else if (ifire) begin
        pf_ptr_q  <= pf_ptr_q + WORD_STEP;
        pf_phys_q <= pf_phys_q + WORD_STEP;
        // Responder back-off or page crossing ends the burst
        if (!iback || !i_fetch_want || (pf_ptr_q[PW-1:0] + WORD_STEP[PW-1:0]) == '0) begin
          ist_q <= ACC_IDLE;
        end
      end
    end
  end
  // Load-test takes the debug word in place of memory
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      o_instr_valid <= 1'b0;
      o_instr       <= '0;
    end else begin
      o_instr_valid <= ifire || (mode_q == MODE_LOADTEST && irdy);
      o_instr       <= instr2_q;
    end
  end

  // ****************************************************************
  // Data access: simple, with pipelined conversion when the responder allows it
  // ****************************************************************
  logic [W-1:0] dphys_q, dnext_addr_q;
  logic         dwr_q, dnext_q;
  logic [1:0]   prot_q;
  logic         daddr_cycle;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      dst_q   <= ACC_IDLE;
      dphys_q <= '0;
      dwr_q   <= 1'b0;
      dnext_q <= 1'b0;
      prot_q  <= PROT_SIMPLE;
      dnext_addr_q <= '0;
    end else begin
      case (dst_q)
        ACC_IDLE: begin
          if (xl_valid && xl_for_data_q && running && !grant_q) begin
            dphys_q <= xl_paddr;
            dwr_q   <= i_data_wr;
            prot_q  <= PROT_SIMPLE;
            dst_q   <= ACC_ADDR;
          end
        end
        ACC_ADDR: begin
          dst_q <= ACC_DATA;
        end
        default: begin
          if (pipe_ok) begin
            prot_q <= PROT_PIPE;
          end
          // One more address may be queued ahead of the reply
          if (xl_valid && xl_for_data_q && !dnext_q && prot_q == PROT_PIPE) begin
            dnext_q      <= 1'b1;
            dnext_addr_q <= xl_paddr;
          end
          if (drdy) begin
            dst_q   <= dnext_q ? ACC_ADDR : ACC_IDLE;
            dnext_q <= 1'b0;
            if (dnext_q) begin
              dphys_q <= dnext_addr_q;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      o_data_done  <= 1'b0;
      o_data_rdata <= '0;
      O_DATA       <= '0;
    end else begin
      o_data_done  <= dst_q == ACC_DATA && drdy;
      o_data_rdata <= data2_q;
      O_DATA       <= i_data_wdata;
    end
  end

  // ****************************************************************
  // Pin drive: test mode and a granted master turn drivers off
  // ****************************************************************
  logic drive;
  assign drive       = mode_q != MODE_TEST && mode_q != MODE_RESET && !grant_q;
  assign daddr_cycle = dst_q == ACC_ADDR;
  // Data address has the shared bus; simple access holds it to the end
  assign O_ADDR      = dst_q != ACC_IDLE ? dphys_q : pf_phys_q;
  assign O_ADDR_OE   = drive;
  assign O_DREQ      = drive && daddr_cycle;
  assign O_IREQ      = drive && ilive && ist_q == ACC_ADDR && dst_q == ACC_IDLE;
  assign O_DWR       = drive && dwr_q;
  assign O_PROT      = drive ? prot_q : PROT_SIMPLE;
  assign O_BURST_REQ = drive && ilive && ist_q == ACC_DATA;
  assign O_PRIV      = drive && (O_IREQ || O_DREQ) && i_supervisor;
  assign O_DATA_OE   = drive && dwr_q && dst_q == ACC_DATA;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_test_entered;
    mode_q == MODE_TEST;
  endsequence
  AST_TEST_QUIET: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    s_test_entered |-> !O_ADDR_OE && !O_DATA_OE && !O_IREQ && !O_DREQ)
    else $error("drivers enabled in test mode");
  AST_RESET_MODE: assert property (@(posedge I_REF_CLK)
    !I_RSTN |=> mode_q == MODE_RESET && dst_q == ACC_IDLE)
    else $error("reset did not initialise state");
  AST_MODE_OUT: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    $past(I_RSTN) |-> O_MODE == $past(mode_d))
    else $error("mode output lags request");
  AST_WAIT_NO_ACC: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    mode_q == MODE_WAIT |-> !o_exec_en && dst_q != ACC_ADDR)
    else $error("activity in wait mode");
  AST_HOLD_RESUME: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    mode_q == MODE_HOLD && !i_hazard && !i_wait_req && !halt_pin && !step_pin && !lt_pin && !test_pin
      && !halt_seen_q && !i_halt_instr |=> mode_q == MODE_EXEC)
    else $error("hold did not resume");
  AST_HALT_QUIET: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    mode_q == MODE_HALT |-> !o_exec_en && !O_BURST_REQ)
    else $error("fetch or execute while halted");
  AST_STEP_ONCE: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    mode_q == MODE_STEP && step_pin && !lt_pin && !test_pin |=> mode_q != MODE_STEP)
    else $error("step lasted more than one stage");
  AST_PRIV: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    O_DREQ |-> O_PRIV == i_supervisor)
    else $error("privilege output wrong in address cycle");
  AST_SIMPLE_HOLD: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    dst_q == ACC_DATA && !drdy && !dnext_q |=> O_ADDR == $past(O_ADDR))
    else $error("address moved during access");
endmodule // chan_master

// ==== chan_partner.sv ====
// Far-side model of the channel: a memory that answers instruction bursts and data accesses.
// Assumes the master's channel pins on the same clock; it answers promptly or slowly on request.
`timescale 1ns/1ps
module chan_partner (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_ireq,
  input  wire logic        i_dreq,
  input  wire logic        i_dwr,
  input  wire logic        i_burst,
  input  wire logic [31:0] i_wdata,
  output logic [31:0]      o_instr,
  output logic             o_irdy,
  output logic             o_iback,
  output logic [31:0]      o_data,
  output logic             o_drdy,
  output logic [31:0]      o_wcap
);
  // ****************************************************************
  // Responder state
  // ****************************************************************
  logic [31:0] iptr;
  logic [31:0] daddr;
  logic [3:0]  dcnt;
  logic [2:0]  words;
  logic        dbusy;
  logic        dwr;
  logic        tick;

  initial begin
    {iptr, daddr, dcnt, words, dbusy, dwr, tick} = '0;
    {o_instr, o_irdy, o_iback, o_data, o_drdy, o_wcap} = '0;
  end

  // Released buses toggle every cycle, so a stale value can never pass as a fresh answer
  always @(posedge i_clk) begin
    tick    <= ~tick;
    o_irdy  <= 1'b0;
    o_drdy  <= 1'b0;
    o_instr <= ~o_instr;
    o_data  <= ~o_data;
    if (i_ireq) begin
      iptr    <= i_addr;
      words   <= 3'h4;
      o_iback <= 1'b1;
    end else if (i_burst && words != 3'h0 && (!i_slow || tick)) begin
      // Words follow sequential addresses; the burst is cut after four words
      o_irdy  <= 1'b1;
      o_instr <= {iptr[15:0], iptr[31:16]};
      iptr    <= iptr + 32'h0000_0004;
      words   <= words - 3'h1;
      o_iback <= (words != 3'h1);
    end
    // Data answer comes late on purpose: the master must hold its address meanwhile
    if (i_dreq) begin
      daddr <= i_addr;
      dwr   <= i_dwr;
      dcnt  <= i_slow ? 4'h6 : 4'h2;
      dbusy <= 1'b1;
    end else if (dbusy) begin
      dcnt <= dcnt - 4'h1;
      if (dcnt == 4'h1) begin
        o_drdy <= 1'b1;
        o_data <= ~daddr;
        dbusy  <= 1'b0;
        if (dwr) begin
          o_wcap <= i_wdata;
        end
      end
    end
  end
endmodule // chan_partner

// ==== tb_chan_master.sv ====
// Self-checking testbench for the channel master and its operating-mode control.
// Assumes chan_pkg, chan_master and the chan_partner far-side model are compiled first.
`timescale 1ns/1ps
module tb_chan_master;
  import chan_pkg::*;
  // ****************************************************************
  // Signals, design and partner
  // ****************************************************************
  logic clk, rstn, sup, wreq, irq, hinstr, hazard, branch, dreq, dwr, fwant, slow;
  logic halt, step, ltest, test, bgreq, pok;
  logic [31:0] bva, dva, dwd, instr, rdata, addr, data_o, pinstr, pdata, wcap;
  logic [21:0] base;
  logic exec_en, ivalid, ddone, dbg_sel, addr_oe, ireq, dreq_o, dwr_o, priv, burst, data_oe, bgrant;
  logic irdy, iback, drdy;
  logic [1:0] prot;
  logic [2:0] mode;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  chan_master i_chan_master (.I_REF_CLK(clk), .I_RSTN(rstn), .i_supervisor(sup), .i_wait_req(wreq),
    .i_irq_enabled(irq), .i_halt_instr(hinstr), .i_hazard(hazard), .i_branch(branch),
    .i_branch_vaddr(bva), .i_data_req(dreq), .i_data_wr(dwr), .i_data_vaddr(dva), .i_data_wdata(dwd),
    .i_page_base(base), .i_fetch_want(fwant), .o_exec_en(exec_en), .o_instr_valid(ivalid),
    .o_instr(instr), .o_data_done(ddone), .o_data_rdata(rdata), .o_dbg_sel(dbg_sel), .O_ADDR(addr),
    .O_ADDR_OE(addr_oe), .O_IREQ(ireq), .O_DREQ(dreq_o), .O_DWR(dwr_o), .O_PROT(prot), .O_PRIV(priv),
    .O_BURST_REQ(burst), .I_INSTR(pinstr), .I_IRDY(irdy), .I_IBACK(iback), .I_DATA(pdata),
    .O_DATA(data_o), .O_DATA_OE(data_oe), .I_DRDY(drdy), .I_PIPE_OK(pok), .I_BGRANT_REQ(bgreq),
    .O_BGRANT(bgrant), .I_HALT(halt), .I_STEP(step), .I_LOADTEST(ltest), .I_TEST(test), .O_MODE(mode));

  chan_partner i_chan_partner (.i_clk(clk), .i_slow(slow), .i_addr(addr), .i_ireq(ireq), .i_dreq(dreq_o),
    .i_dwr(dwr_o), .i_burst(burst), .i_wdata(data_o), .o_instr(pinstr), .o_irdy(irdy), .o_iback(iback),
    .o_data(pdata), .o_drdy(drdy), .o_wcap(wcap));

  // 10 MHz clock; the watchdog ceiling is far above the hundred or so cycles the run needs
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_sim;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Mode pins pass two synchronising flops, so give each change a bounded settling time
  task wait_mode(input op_mode_t m);
    for (int k = 0; k < 30 && mode !== m; k++) @(negedge clk);
    chk(32'(mode), 32'(m));
  endtask

  function automatic logic [31:0] xlate(input logic [31:0] va);
    return {va[31:PAGE_W] + base, va[PAGE_W-1:0]};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_data(input logic w, input logic [31:0] va, input logic [31:0] wd, input logic s);
    @(negedge clk);
    {sup, dwr, dva, dwd, dreq} = {s, w, va, wd, 1'b1};
    @(negedge clk);
    dreq = 1'b0;
    for (int k = 0; k < 10 && dreq_o !== 1'b1; k++) @(negedge clk);
    chk(addr, xlate(va));
    chk(32'(priv), 32'(s));
    chk(32'(dwr_o), 32'(w));
    @(negedge clk);
    chk(addr, xlate(va));
    for (int k = 0; k < 30 && ddone !== 1'b1; k++) @(negedge clk);
    chk(32'(ddone), 32'h1);
    if (w) chk(wcap, wd);
    else chk(rdata, ~xlate(va));
  endtask

  // Burst starts two words before a page end, so the pointer must be translated again
  task t_fetch(input logic [31:0] va);
    logic [31:0] pa;
    logic [31:0] ia [2];
    int n;
    int r;
    pa = xlate(va);
    n = 0;
    r = 0;
    {slow, fwant, bva, branch} = {1'b1, 1'b1, va, 1'b1};
    @(negedge clk);
    branch = 1'b0;
    for (int k = 0; k < 80 && n < 3; k++) begin
      @(negedge clk);
      if (ireq === 1'b1 && r < 2) begin
        ia[r] = addr;
        r++;
      end
      if (ivalid === 1'b1) begin
        chk(instr, {pa[15:0] + 16'(4 * n), pa[31:16]} );
        n++;
      end
    end
    chk(32'(n), 32'h3);
    chk(ia[0], pa);
    chk(ia[1], pa + 32'h0000_0008);
    {slow, fwant} = 2'b00;
  endtask

  task t_modes;
    {fwant, wreq} = 2'b11;
    wait_mode(MODE_WAIT);
    chk(32'({ireq, dreq_o}), 32'h0);
    irq = 1'b1;
    wait_mode(MODE_EXEC);
    {wreq, irq, hazard} = 3'b001;
    wait_mode(MODE_HOLD);
    chk(32'(exec_en), 32'h0);
    hazard = 1'b0;
    wait_mode(MODE_EXEC);
    hinstr = 1'b1;
    @(negedge clk);
    hinstr = 1'b0;
    wait_mode(MODE_HALT);
    repeat (3) @(negedge clk);
    chk(32'({exec_en, ireq}), 32'h0);
    step = 1'b1;
    wait_mode(MODE_STEP);
    chk(32'(exec_en), 32'h1);
    @(negedge clk);
    chk(32'(mode), 32'(MODE_HALT));
    step = 1'b0;
    wait_mode(MODE_EXEC);
    ltest = 1'b1;
    wait_mode(MODE_LOADTEST);
    chk(32'(dbg_sel), 32'h1);
    ltest = 1'b0;
    wait_mode(MODE_EXEC);
    test = 1'b1;
    repeat (4) @(negedge clk);
    chk(32'({addr_oe, data_oe}), 32'h0);
    {test, fwant, bgreq} = 3'b001;
    for (int k = 0; k < 20 && bgrant !== 1'b1; k++) @(negedge clk);
    chk(32'(bgrant), 32'h1);
    bgreq = 1'b0;
  endtask

  // Reset must win over a pending external halt
  task t_reset_prio;
    halt = 1'b1;
    wait_mode(MODE_HALT);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    chk(32'(mode), 32'(MODE_RESET));
    chk(32'({addr_oe, data_oe, ireq, dreq_o}), 32'h0);
    {halt, rstn} = 2'b01;
    wait_mode(MODE_EXEC);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rstn, sup, wreq, irq, hinstr, hazard, branch, dreq, dwr, fwant, slow} = '0;
    {halt, step, ltest, test, bgreq, pok, bva, dva, dwd} = '0;
    base = 22'h000123;
    repeat (3) @(negedge clk);
    chk(32'(mode), 32'(MODE_RESET));
    chk(32'({addr_oe, data_oe}), 32'h0);
    rstn = 1'b1;
    wait_mode(MODE_EXEC);
    t_data(1'b0, 32'h0000_1a40, 32'h0, 1'b1);
    t_data(1'b1, 32'h0004_0208, 32'hc0de_5a17, 1'b0);
    // Responder offers pipelining: the simple access must be converted
    pok = 1'b1;
    t_data(1'b0, 32'h0000_2c10, 32'h0, 1'b0);
    chk(32'(prot), 32'(PROT_PIPE));
    pok = 1'b0;
    t_fetch(32'h0002_03f8);
    t_modes;
    t_reset_prio;
    t_data(1'b0, 32'hffff_fffc, 32'h0, 1'b1);
    end_sim;
  end
endmodule // tb_chan_master
